/* rtl/hti_iface.v */
`timescale 1ns/1ps
`default_nettype none
`include "hti_consts.vh"
module hti_iface #(
  parameter [31:0] BASE_ADDR  = `HTI_BASE_ADDR,
  parameter        ADDR_SHIFT = `HTI_ADDR_SHIFT,
  parameter        MEM_DEPTH  = 256,
  parameter        MEM_AW     = 8
) (
  input  wire        sys_clk,
  input  wire        reset,
  input  wire        sys_cs,
  input  wire        sys_wr,
  input  wire [31:0] sys_addr,
  input  wire [31:0] sys_wdata,
  output reg  [31:0] sys_rdata,
  output reg         sys_ack,
  output wire        mst_req,
  output wire        mst_rnw,
  output wire [31:0] mst_addr,
  output wire [31:0] mst_wdata,
  input  wire        mst_ack,
  input  wire [31:0] mst_rdata,
  output reg  [0:3]  iface_to_logic_status, // see R12
  output reg  [0:31] iface_to_logic_result, // see R12
  input  wire [0:7]  logic_to_iface_opcode,
  input  wire [0:31] logic_to_iface_arg_first,
  input  wire [0:31] logic_to_iface_arg_second
);
  localparam [1:0] C_HALT    = 2'd0;
  localparam [1:0] C_IDLE    = 2'd1;
  localparam [1:0] C_BUSY    = 2'd2;
  localparam [1:0] C_BLOCKED = 2'd3;

  reg  [7:0]  owner_thread_number;
  reg  [31:0] verification_word;
  reg  [7:0]  system_state;
  reg  [31:0] kernel_command;
  reg  [31:0] start_argument;
  reg  [31:0] return_value;
  reg  [31:0] bus_fetch_port;
  reg  [31:0] bus_store_port;
  reg  [31:0] diag_control;

  reg  [1:0]  ctl_state;
  reg  [7:0]  op;
  reg         op_local;
  reg  [7:0]  timer;
  reg  [7:0]  budget;
  reg         op_done;
  reg  [1:0]  settle;
  reg         bm_start;
  reg         bm_rnw;
  reg  [31:0] bm_addr;
  reg  [31:0] bm_data;
  reg         mem_we;
  reg  [MEM_AW-1:0] mem_addr;
  reg  [31:0] mem_wdata;
  reg  [31:0] rd_mux;

  wire        bm_done;
  wire [31:0] bm_rdata;
  wire [31:0] mem_rdata;
  wire [31:0] a1 = logic_to_iface_arg_first;
  wire [31:0] a2 = logic_to_iface_arg_second;
  wire [7:0]  opc = logic_to_iface_opcode;
  wire [31:0] loc_off = a1 - `HTI_LOCAL_BASE;
  wire        a1_local = (a1 >= `HTI_LOCAL_BASE) &&
                         (loc_off[31:2] < MEM_DEPTH);
  wire [5:0]  mutex_num = logic_to_iface_arg_first[26:31]; // see R17
  wire        win_hit = ((sys_addr & `HTI_WIN_MASK) ==
                         (BASE_ADDR & `HTI_WIN_MASK));
  wire        access = sys_cs && win_hit && !sys_ack;
  wire        wr_acc = access && sys_wr;

  // system address of a register: base plus scaled offset
  function hit;
    input [31:0] addr;
    input [31:0] off;
    begin
      hit = (addr == BASE_ADDR + (off << ADDR_SHIFT)); // see R9
    end
  endfunction

  // cycle budget from opcode issue to run, per request kind
  function [7:0] op_budget;
    input [7:0] code;
    input       local_hit;
    begin
      if (code == `HTI_OP_READ)
        op_budget = local_hit ? `HTI_T_LLOAD : `HTI_T_GLOAD; // see R4
      else if (code == `HTI_OP_WRITE)
        op_budget = local_hit ? `HTI_T_LSTORE : `HTI_T_GSTORE; // see R5
      else if (code == `HTI_OP_LOCK || code == `HTI_OP_UNLOCK)
        op_budget = `HTI_T_MUTEX; // see R7
      else
        op_budget = `HTI_T_SHORT; // see R6
    end
  endfunction

  always @*
  begin
    rd_mux = 32'h0000_0000;
    if (hit(sys_addr, `HTI_OFF_OWNER))
      rd_mux = {24'h00_0000, owner_thread_number};
    else if (hit(sys_addr, `HTI_OFF_VERIFY))
      rd_mux = verification_word;
    else if (hit(sys_addr, `HTI_OFF_STATE))
      rd_mux = {24'h00_0000, system_state};
    else if (hit(sys_addr, `HTI_OFF_COMMAND))
      rd_mux = kernel_command;
    else if (hit(sys_addr, `HTI_OFF_START_ARG))
      rd_mux = start_argument;
    else if (hit(sys_addr, `HTI_OFF_RETURN))
      rd_mux = return_value;
    else if (hit(sys_addr, `HTI_OFF_FETCH))
      rd_mux = bus_fetch_port;
    else if (hit(sys_addr, `HTI_OFF_STORE))
      rd_mux = bus_store_port;
    else if (hit(sys_addr, `HTI_OFF_DIAG_SYS)) // see R10
      rd_mux = {14'h0000, ctl_state, timer, system_state};
    else if (hit(sys_addr, `HTI_OFF_DIAG_LOGIC))
      rd_mux = {12'h000, iface_to_logic_status, op, timer};
    else if (hit(sys_addr, `HTI_OFF_DIAG_CTRL))
      rd_mux = diag_control;
  end

  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      sys_rdata             <= 32'h0000_0000;
      sys_ack               <= 1'b0;
      owner_thread_number   <= 8'h00;
      verification_word     <= 32'h0000_0000;
      system_state          <= `HTI_SYS_FREE;
      kernel_command        <= 32'h0000_0000;
      start_argument        <= 32'h0000_0000;
      return_value          <= 32'h0000_0000;
      bus_fetch_port        <= 32'h0000_0000;
      bus_store_port        <= 32'h0000_0000;
      diag_control          <= 32'h0000_0000;
      iface_to_logic_status <= `HTI_ST_RESET; // see R14
      iface_to_logic_result <= 32'h0000_0000;
      ctl_state             <= C_HALT;
      op                    <= `HTI_OP_NOOP;
      op_local              <= 1'b0;
      timer                 <= 8'h00;
      budget                <= 8'h00;
      op_done               <= 1'b0;
      settle                <= 2'h0;
      bm_start              <= 1'b0;
      bm_rnw                <= 1'b1;
      bm_addr               <= 32'h0000_0000;
      bm_data               <= 32'h0000_0000;
      mem_we                <= 1'b0;
      mem_addr              <= {MEM_AW{1'b0}};
      mem_wdata             <= 32'h0000_0000;
    end
    else
    begin
      sys_ack  <= access;
      bm_start <= 1'b0;
      mem_we   <= 1'b0;
      if (access && !sys_wr)
        sys_rdata <= rd_mux;
      if (settle != 2'h0)
        settle <= settle - 2'h1;
      if (bm_done)
        bus_fetch_port <= bm_rdata;

      case (ctl_state)
        C_IDLE:
        begin
          // two quiet cycles after run before taking a new request
          if (iface_to_logic_status == `HTI_ST_RUN && settle == 2'h0 &&
              opc != `HTI_OP_NOOP) // see R11
          begin
            iface_to_logic_status <= `HTI_ST_ACK; // see R16
            ctl_state <= C_BUSY;
            op        <= opc;
            op_local  <= a1_local;
            budget    <= op_budget(opc, a1_local);
            timer     <= 8'h01;
            op_done   <= 1'b0;
            mem_addr  <= loc_off[MEM_AW+1:2];
            if (opc == `HTI_OP_READ || opc == `HTI_OP_WRITE) // see R15
            begin
              if (a1_local)
              begin
                mem_we    <= (opc == `HTI_OP_WRITE); // see R5
                mem_wdata <= a2;
                op_done   <= 1'b1;
              end
              else
              begin
                bm_start <= 1'b1; // see R4
                bm_rnw   <= (opc == `HTI_OP_READ);
                bm_addr  <= a1;
                bm_data  <= a2;
                if (opc == `HTI_OP_WRITE)
                  bus_store_port <= a2;
              end
            end
            else if (opc == `HTI_OP_LOCK || opc == `HTI_OP_UNLOCK)
            begin
              bm_start <= 1'b1; // see R7
              bm_rnw   <= 1'b1;
              bm_addr  <= ((opc == `HTI_OP_LOCK) ? `HTI_LOCK_BASE :
                          `HTI_UNLOCK_BASE) |
                          {16'h0000, mutex_num, owner_thread_number, 2'b00};
            end
            else if (opc == `HTI_OP_EXIT || opc == `HTI_OP_EXIT_ERR)
            begin
              bm_start     <= 1'b1; // see R8
              bm_rnw       <= 1'b1;
              bm_addr      <= `HTI_EXIT_BASE |
                              {22'h00_0000, owner_thread_number, 2'b00};
              return_value <= a1;
            end
            else if (opc == `HTI_OP_SELF)
            begin
              iface_to_logic_result <= {24'h00_0000, owner_thread_number};
              op_done <= 1'b1;
            end
            else
            begin
              // yield and undefined codes are simply acknowledged
              op_done <= 1'b1;
            end
          end
        end
        C_BUSY:
        begin
          timer <= timer + 8'h01;
          if (bm_done)
            op_done <= 1'b1;
          if (bm_done && op == `HTI_OP_READ)
            iface_to_logic_result <= bm_rdata;
          if (bm_done && (op == `HTI_OP_EXIT || op == `HTI_OP_EXIT_ERR))
          begin
            // exit is not padded: system status flips as the transfer ends
            system_state <= (op == `HTI_OP_EXIT) ? `HTI_SYS_EXITED :
                            `HTI_SYS_EXITED_ERR; // see R8
            ctl_state <= C_HALT;
          end
          else if (bm_done && op == `HTI_OP_LOCK &&
                   !bm_rdata[`HTI_LOCK_GRANT_BIT])
          begin
            system_state <= `HTI_SYS_BLOCKED; // status stays at ack
            ctl_state    <= C_BLOCKED;
          end
          else if ((op_done || bm_done) && timer >= budget - 8'h01)
          begin
            // a fast completion is held back to the fixed budget
            if (op == `HTI_OP_READ && op_local)
              iface_to_logic_result <= mem_rdata; // see R5
            iface_to_logic_status <= `HTI_ST_RUN; // see R16
            settle    <= `HTI_T_SETTLE;
            ctl_state <= C_IDLE;
          end
        end
        default:
        begin
        end
      endcase

      // kernel writes come last so they override the controller
      if (wr_acc)
      begin
        if (hit(sys_addr, `HTI_OFF_OWNER))
        begin
          owner_thread_number <= sys_wdata[7:0];
          if (system_state == `HTI_SYS_FREE)
            system_state <= `HTI_SYS_USED; // see R1
        end
        else if (hit(sys_addr, `HTI_OFF_VERIFY))
          verification_word <= sys_wdata;
        else if (hit(sys_addr, `HTI_OFF_COMMAND))
        begin
          kernel_command <= sys_wdata;
          if (sys_wdata == `HTI_CMD_RESET)
          begin
            iface_to_logic_status <= `HTI_ST_RESET; // see R3
            system_state <= `HTI_SYS_FREE;
            ctl_state    <= C_HALT;
          end
          else if (sys_wdata == `HTI_CMD_RUN &&
                   (system_state == `HTI_SYS_USED ||
                    system_state == `HTI_SYS_BLOCKED))
          begin
            // a run while blocked is taken as the lock being granted
            iface_to_logic_status <= `HTI_ST_RUN; // see R2
            system_state <= `HTI_SYS_RUNNING;
            settle       <= `HTI_T_SETTLE;
            ctl_state    <= C_IDLE;
          end
        end
        else if (hit(sys_addr, `HTI_OFF_START_ARG))
          start_argument <= sys_wdata;
        else if (hit(sys_addr, `HTI_OFF_RETURN))
          return_value <= sys_wdata;
        else if (hit(sys_addr, `HTI_OFF_FETCH))
          bus_fetch_port <= sys_wdata;
        else if (hit(sys_addr, `HTI_OFF_STORE))
          bus_store_port <= sys_wdata;
        else if (hit(sys_addr, `HTI_OFF_DIAG_CTRL))
          diag_control <= sys_wdata;
      end
    end
  end

  hti_bus_master u_master (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .start      (bm_start),
    .abort      (wr_acc && hit(sys_addr, `HTI_OFF_COMMAND) &&
                 sys_wdata == `HTI_CMD_RESET),
    .start_rnw  (bm_rnw),
    .start_addr (bm_addr),
    .start_data (bm_data),
    .done       (bm_done),
    .rdata      (bm_rdata),
    .mst_req    (mst_req),
    .mst_rnw    (mst_rnw),
    .mst_addr   (mst_addr),
    .mst_wdata  (mst_wdata),
    .mst_ack    (mst_ack),
    .mst_rdata  (mst_rdata)
  );

  hti_local_mem #(
    .DEPTH (MEM_DEPTH),
    .AW    (MEM_AW)
  ) u_mem (
    .sys_clk (sys_clk),
    .reset   (reset),
    .we      (mem_we),
    .addr    (mem_addr),
    .wdata   (mem_wdata),
    .rdata   (mem_rdata)
  );
endmodule
`default_nettype wire

/* rtl/hti_consts.vh */
// Operation
// R1 - owner number write marks slot taken quickly
// R2 - run command sets logic status run
// R3 - reset command returns logic status reset
// R4 - global load 60, store 32 cycles
// R5 - local load 5, local store 4
// R6 - yield and self answer in 5
// R7 - mutex acquire and release take 20
// R8 - exit ends transfer, system status exited
// R9 - registers decode at base plus offset
// R10 - owner, command, debug registers at fixed offsets
// R11 - start, stop, calls only via handshake
// R12 - status 4 bits, result 32, bit0 msb
// R13 - opcode 8 bits, arguments 32, bit0 msb
// R14 - status one-hot: reset, run, ack, pause
// R15 - fixed opcode encoding table
// R16 - request gives ack, fulfilment gives run
// R17 - mutex number from argument bits 26-31
// R18 - logic holds request until ack seen
`ifndef HTI_CONSTS_VH
`define HTI_CONSTS_VH

`define HTI_BASE_ADDR      32'h6300_0000
`define HTI_ADDR_SHIFT     4
`define HTI_WIN_MASK       32'hFFFF_F000

`define HTI_OFF_OWNER      32'h0000_0000
`define HTI_OFF_VERIFY     32'h0000_0004
`define HTI_OFF_STATE      32'h0000_0008
`define HTI_OFF_COMMAND    32'h0000_000C
`define HTI_OFF_START_ARG  32'h0000_0010
`define HTI_OFF_RETURN     32'h0000_0018
`define HTI_OFF_FETCH      32'h0000_0020
`define HTI_OFF_STORE      32'h0000_0024
`define HTI_OFF_DIAG_SYS   32'h0000_0028
`define HTI_OFF_DIAG_LOGIC 32'h0000_002C
`define HTI_OFF_DIAG_CTRL  32'h0000_0030

`define HTI_ST_RESET       4'h1
`define HTI_ST_RUN         4'h2
`define HTI_ST_ACK         4'h4
`define HTI_ST_PAUSE       4'h8

`define HTI_OP_NOOP        8'h00
`define HTI_OP_EXIT        8'h01
`define HTI_OP_EXIT_ERR    8'h09
`define HTI_OP_READ        8'h02
`define HTI_OP_WRITE       8'h03
`define HTI_OP_SELF        8'h04
`define HTI_OP_YIELD       8'h05
`define HTI_OP_LOCK        8'h06
`define HTI_OP_UNLOCK      8'h07

`define HTI_SYS_FREE       8'h01
`define HTI_SYS_USED       8'h02
`define HTI_SYS_RUNNING    8'h04
`define HTI_SYS_BLOCKED    8'h08
`define HTI_SYS_EXITED     8'h10
`define HTI_SYS_EXITED_ERR 8'h20

`define HTI_CMD_RESET      32'h0000_0001
`define HTI_CMD_RUN        32'h0000_0002

`define HTI_LOCAL_BASE     32'h6300_8000
`define HTI_LOCK_BASE      32'h6400_0000
`define HTI_UNLOCK_BASE    32'h6401_0000
`define HTI_EXIT_BASE      32'h6500_0000
`define HTI_LOCK_GRANT_BIT 0

`define HTI_T_GLOAD        8'd60
`define HTI_T_GSTORE       8'd32
`define HTI_T_LLOAD        8'd5
`define HTI_T_LSTORE       8'd4
`define HTI_T_SHORT        8'd5
`define HTI_T_MUTEX        8'd20
`define HTI_T_SETTLE       2'd2

`endif

/* rtl/hti_local_mem.v */
`timescale 1ns/1ps
`default_nettype none
module hti_local_mem #(
  parameter DEPTH = 256,
  parameter AW    = 8
) (
  input  wire          sys_clk,
  input  wire          reset,
  input  wire          we,
  input  wire [AW-1:0] addr,
  input  wire [31:0]   wdata,
  output reg  [31:0]   rdata
);
  // contents are not cleared by reset, as block memory cannot be
  reg [31:0] mem [0:DEPTH-1];

  always @(posedge sys_clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
  end

  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      rdata <= 32'h0000_0000;
    end
    else
    begin
      rdata <= mem[addr];
    end
  end
endmodule
`default_nettype wire

/* rtl/hti_bus_master.v */
`timescale 1ns/1ps
`default_nettype none
module hti_bus_master (
  input  wire        sys_clk,
  input  wire        reset,
  input  wire        start,
  input  wire        abort,
  input  wire        start_rnw,
  input  wire [31:0] start_addr,
  input  wire [31:0] start_data,
  output reg         done,
  output reg  [31:0] rdata,
  output reg         mst_req,
  output reg         mst_rnw,
  output reg  [31:0] mst_addr,
  output reg  [31:0] mst_wdata,
  input  wire        mst_ack,
  input  wire [31:0] mst_rdata
);
  always @(posedge sys_clk)
  begin
    if (reset || abort)
    begin
      done      <= 1'b0;
      rdata     <= 32'h0000_0000;
      mst_req   <= 1'b0;
      mst_rnw   <= 1'b1;
      mst_addr  <= 32'h0000_0000;
      mst_wdata <= 32'h0000_0000;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        mst_req   <= 1'b1;
        mst_rnw   <= start_rnw;
        mst_addr  <= start_addr;
        mst_wdata <= start_data;
      end
      else if (mst_req && mst_ack)
      begin
        // request stays up until the slave answers or a reset command aborts it; no timeout
        mst_req <= 1'b0;
        done    <= 1'b1;
        rdata   <= mst_rdata;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/hti_iface_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hti_consts.vh"
module hti_iface_asserts #(
  parameter [31:0] BASE_ADDR  = `HTI_BASE_ADDR,
  parameter        ADDR_SHIFT = `HTI_ADDR_SHIFT,
  parameter        MEM_DEPTH  = 256
) (
  input wire        sys_clk,
  input wire        reset,
  input wire        sys_cs,
  input wire        sys_wr,
  input wire [31:0] sys_addr,
  input wire [31:0] sys_wdata,
  input wire        sys_ack,
  input wire        mst_req,
  input wire [31:0] mst_addr,
  input wire        mst_ack,
  input wire [31:0] mst_rdata,
  input wire [0:3]  iface_to_logic_status,
  input wire [0:7]  logic_to_iface_opcode,
  input wire [0:31] logic_to_iface_arg_first
);
  wire in_win = (sys_addr & `HTI_WIN_MASK) == (BASE_ADDR & `HTI_WIN_MASK);
  wire run = iface_to_logic_status == `HTI_ST_RUN;
  wire ack = iface_to_logic_status == `HTI_ST_ACK;
  wire [31:0] cmd_addr = BASE_ADDR + (`HTI_OFF_COMMAND << ADDR_SHIFT);
  // opcode and locality as seen at the taking edge, one cycle before ack
  reg [7:0] op_q;
  reg       loc_q;
  // a lock answered without the grant bit leaves the status at ack
  reg       refused;
  always @(posedge sys_clk)
  begin
    op_q  <= logic_to_iface_opcode;
    if (mst_req && mst_ack)
      refused <= !mst_rdata[0] &&
                 (mst_addr & 32'hFFFF_0000) == `HTI_LOCK_BASE;
    loc_q <= logic_to_iface_arg_first >= `HTI_LOCAL_BASE &&
             logic_to_iface_arg_first < `HTI_LOCAL_BASE + 4 * MEM_DEPTH;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_reg_ack_next: assert property (sys_cs && in_win && !sys_ack |=> sys_ack)
    else $error("register access not acknowledged");
  a_no_stray_ack: assert property (sys_ack |-> $past(sys_cs && in_win))
    else $error("acknowledge without access");
  a_status_onehot: assert property ($onehot(iface_to_logic_status))
    else $error("status not one-hot");
  a_noop_ignored: assert property (run && logic_to_iface_opcode == 8'h00 |=> !ack)
    else $error("noop acknowledged");
  a_req_acked: assert property (run [*4] ##0 logic_to_iface_opcode != 8'h00
    |=> ack)
    else $error("request not acknowledged");
  a_reset_cmd: assert property (sys_ack && $past(sys_cs && sys_wr &&
    sys_addr == cmd_addr && sys_wdata == `HTI_CMD_RESET)
    |-> ##[0:3] iface_to_logic_status == `HTI_ST_RESET)
    else $error("reset command too slow");
  a_local_load: assert property ($rose(ack) && op_q == `HTI_OP_READ && loc_q
    |-> ack [*4] ##1 run)
    else $error("local load timing");
  a_local_store: assert property ($rose(ack) && op_q == `HTI_OP_WRITE && loc_q
    |-> ack [*3] ##1 run)
    else $error("local store timing");
  a_global_load: assert property ($rose(ack) && op_q == `HTI_OP_READ && !loc_q
    |-> ##59 run)
    else $error("global load timing");
  a_global_store: assert property ($rose(ack) && op_q == `HTI_OP_WRITE &&
    !loc_q |-> ##31 run)
    else $error("global store timing");
  a_short_calls: assert property ($rose(ack) && (op_q == `HTI_OP_SELF ||
    op_q == `HTI_OP_YIELD) |-> ack [*4] ##1 run)
    else $error("self or yield timing");
  a_mutex_time: assert property ($rose(ack) && (op_q == `HTI_OP_LOCK ||
    op_q == `HTI_OP_UNLOCK) |-> ##19 (run || refused))
    else $error("mutex timing");
  a_refused_holds: assert property ($rose(ack) && op_q == `HTI_OP_LOCK
    ##19 refused |-> ack)
    else $error("refused lock left ack");
  a_master_hold: assert property (mst_req && !mst_ack && !sys_cs
    |=> mst_req && $stable(mst_addr))
    else $error("master request dropped early");
  cover property ($rose(ack) && op_q == `HTI_OP_LOCK);
  cover property (run ##1 ack);
  cover property (mst_req && mst_ack);
endmodule
bind hti_iface hti_iface_asserts #(.BASE_ADDR(BASE_ADDR),
  .ADDR_SHIFT(ADDR_SHIFT), .MEM_DEPTH(MEM_DEPTH)) chk_i (
  .sys_clk(sys_clk), .reset(reset), .sys_cs(sys_cs), .sys_wr(sys_wr),
  .sys_addr(sys_addr), .sys_wdata(sys_wdata), .sys_ack(sys_ack),
  .mst_req(mst_req), .mst_addr(mst_addr), .mst_ack(mst_ack),
  .mst_rdata(mst_rdata),
  .iface_to_logic_status(iface_to_logic_status),
  .logic_to_iface_opcode(logic_to_iface_opcode),
  .logic_to_iface_arg_first(logic_to_iface_arg_first));
`default_nettype wire

/* dv/hti_logic_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hti_consts.vh"
module hti_logic_model (
  input  wire         sys_clk,
  input  wire  [0:3]  status,
  input  wire  [0:31] result,
  output logic [0:7]  opcode,
  output logic [0:31] arg_first,
  output logic [0:31] arg_second
);
  initial opcode = `HTI_OP_NOOP;
  initial arg_first = 32'h0;
  initial arg_second = 32'h0;
  // one call; n counts edges from issue to run, 100 means no answer
  task automatic call(input logic [7:0] op, input logic [31:0] a1, a2,
                      input int lag, output logic [31:0] n, res);
    int k;
    k = 0;
    n = 0;
    // settle time after run before a new request may be taken
    repeat (3) @(posedge sys_clk);
    #1;
    opcode = op;
    arg_first = a1;
    arg_second = a2;
    while (n < 100)
    begin
      @(posedge sys_clk);
      #1;
      n = n + 1;
      if (opcode == `HTI_OP_NOOP && status === `HTI_ST_RUN)
        break;
      if (status === `HTI_ST_ACK)
        k = k + 1;
      if (k > lag && opcode != `HTI_OP_NOOP)
      begin
        // released argument lines show the inverse so stale values cannot pass
        opcode = `HTI_OP_NOOP;
        arg_first = ~arg_first;
        arg_second = ~arg_second;
      end
    end
    res = result;
  endtask
endmodule
`default_nettype wire

/* dv/test_hw_thread_interface_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hti_consts.vh"
module test_hw_thread_interface_ctrl;
  logic        sys_clk = 0, reset = 1, sys_cs = 0, sys_wr = 0, mst_ack = 0;
  logic [31:0] sys_addr = 0, sys_wdata = 0, mst_rdata = 0;
  logic [31:0] sys_rdata, mst_addr, mst_wdata, last_addr, last_wdata, n, q;
  logic        sys_ack, mst_req, mst_rnw, last_rnw, got, grant = 1;
  logic [0:3]  status;
  logic [0:31] result, arg1, arg2;
  logic [0:7]  opcode;
  int          n_fail = 0, check_count = 0, cyc = 0, wcnt = 0;
  always #4 sys_clk = ~sys_clk;
  hti_iface dut (.sys_clk(sys_clk), .reset(reset), .sys_cs(sys_cs),
    .sys_wr(sys_wr), .sys_addr(sys_addr), .sys_wdata(sys_wdata),
    .sys_rdata(sys_rdata), .sys_ack(sys_ack), .mst_req(mst_req),
    .mst_rnw(mst_rnw), .mst_addr(mst_addr), .mst_wdata(mst_wdata),
    .mst_ack(mst_ack), .mst_rdata(mst_rdata),
    .iface_to_logic_status(status), .iface_to_logic_result(result),
    .logic_to_iface_opcode(opcode), .logic_to_iface_arg_first(arg1),
    .logic_to_iface_arg_second(arg2));
  hti_logic_model ul (.sys_clk(sys_clk), .status(status), .result(result),
    .opcode(opcode), .arg_first(arg1), .arg_second(arg2));
  task final_report;
    if (n_fail == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      n_fail = n_fail + 1;
      final_report;
    end
  end
  // bus slave: acks after a short wait, data line changes while idle
  always @(posedge sys_clk)
  begin
    #1;
    if (mst_req === 1'b1 && !mst_ack && wcnt == 2)
    begin
      mst_ack = 1;
      mst_rdata = mst_addr | {31'h0, grant};
      last_addr = mst_addr;
      last_rnw = mst_rnw;
      last_wdata = mst_wdata;
      wcnt = 0;
    end
    else
    begin
      mst_ack = 0;
      mst_rdata = ~mst_rdata;
      if (mst_req === 1'b1)
        wcnt = wcnt + 1;
    end
  end
  task chk(input logic [31:0] seen, exp);
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task acc(input logic wr, input logic [31:0] a, d);
    int k;
    @(posedge sys_clk);
    #1;
    sys_cs = 1;
    sys_wr = wr;
    sys_addr = a;
    sys_wdata = d;
    got = 0;
    for (k = 0; k < 8 && !got; k++)
    begin
      @(posedge sys_clk);
      got = sys_ack === 1'b1;
    end
    q = sys_rdata;
    #1 sys_cs = 0;
  endtask
  function automatic [31:0] ra(input [31:0] off);
    ra = `HTI_BASE_ADDR + (off << `HTI_ADDR_SHIFT);
  endfunction
  task rdc(input [31:0] off, exp);
    acc(0, ra(off), 32'h0);
    chk(q, exp);
  endtask
  task ws(input [3:0] e);
    n = 0;
    while (status !== e && n < 20)
    begin
      @(posedge sys_clk);
      #1 n = n + 1;
    end
  endtask
  task one(input [7:0] op, input [31:0] a1, a2, ne, re, input int lag);
    ul.call(op, a1, a2, lag, n, q);
    chk(n, ne);
    if (op == `HTI_OP_READ || op == `HTI_OP_SELF)
      chk(q, re);
  endtask
  task t_regs;
    rdc(`HTI_OFF_STATE, `HTI_SYS_FREE);
    acc(1, ra(`HTI_OFF_VERIFY), 32'h1234_ABCD);
    rdc(`HTI_OFF_VERIFY, 32'h1234_ABCD);
    acc(0, 32'h6300_03F0, 32'h0);
    chk(q, 32'h0);
    chk(got, 1);
    acc(1, 32'h6300_10C0, `HTI_CMD_RUN);
    chk(got, 0);
    acc(1, ra(`HTI_OFF_OWNER), 32'h0000_0007);
    rdc(`HTI_OFF_STATE, `HTI_SYS_USED);
  endtask
  task t_run;
    chk(status, `HTI_ST_RESET);
    acc(1, 32'h6300_00C0, `HTI_CMD_RUN);
    ws(`HTI_ST_RUN);
    chk(n <= 4, 1);
    rdc(`HTI_OFF_STATE, `HTI_SYS_RUNNING);
  endtask
  task t_calls;
    one(`HTI_OP_SELF, 0, 0, 5, 32'h7, 0);
    one(`HTI_OP_YIELD, 0, 0, 5, 0, 2);
    one(`HTI_OP_WRITE, `HTI_LOCAL_BASE + 8, 32'h5A5A_1234, 4, 0, 0);
    one(`HTI_OP_READ, `HTI_LOCAL_BASE + 8, 0, 5, 32'h5A5A_1234, 0);
    one(`HTI_OP_WRITE, 32'h7000_0010, 32'hC3C3_0001, 32, 0, 0);
    chk(last_addr, 32'h7000_0010);
    chk(last_wdata, 32'hC3C3_0001);
    chk(last_rnw, 0);
    one(`HTI_OP_READ, 32'h7000_0020, 0, 60, 32'h7000_0021, 0);
    one(`HTI_OP_LOCK, 32'h5, 0, 20, 0, 0);
    chk(last_addr, `HTI_LOCK_BASE | 32'h141C);
    one(`HTI_OP_UNLOCK, 32'h5, 0, 20, 0, 0);
    chk(last_addr, `HTI_UNLOCK_BASE | 32'h141C);
    grant = 0;
    one(`HTI_OP_LOCK, 32'h5, 0, 100, 0, 0);
    rdc(`HTI_OFF_STATE, `HTI_SYS_BLOCKED);
    grant = 1;
    acc(1, ra(`HTI_OFF_COMMAND), `HTI_CMD_RUN);
    ws(`HTI_ST_RUN);
    chk(status, `HTI_ST_RUN);
    rdc(`HTI_OFF_STATE, `HTI_SYS_RUNNING);
    one(`HTI_OP_EXIT, 32'hBEEF_0001, 0, 100, 0, 0);
    rdc(`HTI_OFF_STATE, `HTI_SYS_EXITED);
    chk(last_addr, `HTI_EXIT_BASE | 32'h1C);
    rdc(`HTI_OFF_RETURN, 32'hBEEF_0001);
  endtask
  task t_reset;
    acc(1, ra(`HTI_OFF_COMMAND), `HTI_CMD_RESET);
    ws(`HTI_ST_RESET);
    chk(n <= 3, 1);
    rdc(`HTI_OFF_STATE, `HTI_SYS_FREE);
    acc(1, ra(`HTI_OFF_OWNER), 32'h0000_0007);
    t_run;
    one(`HTI_OP_EXIT_ERR, 0, 0, 100, 0, 0);
    rdc(`HTI_OFF_STATE, `HTI_SYS_EXITED_ERR);
  endtask
  initial
  begin
    repeat (5) @(posedge sys_clk);
    #1 reset = 0;
    t_regs;
    t_run;
    t_calls;
    t_reset;
    final_report;
  end
endmodule
`default_nettype wire
